/* File: rtl/jsc_map.svh */
// constants for the scan chain and clock switch block
`ifndef JSC_MAP_SVH
`define JSC_MAP_SVH

// ----------------------------------------------------------------------
// instruction codes
// ----------------------------------------------------------------------
`define JSC_IR_LEN        4
`define JSC_IR_EXTEST     4'h0
`define JSC_IR_SCAN_N     4'h2
`define JSC_IR_SAMPLE     4'h3
`define JSC_IR_CLAMP      4'h5
`define JSC_IR_HIGHZ      4'h7
`define JSC_IR_CLAMPZ     4'h9
`define JSC_IR_INTEST     4'hC
`define JSC_IR_IDCODE     4'hE
`define JSC_IR_BYPASS     4'hF
`define JSC_IR_CAPTURE    4'h1

// ----------------------------------------------------------------------
// chain select
// ----------------------------------------------------------------------
`define JSC_SEL_LEN       4
`define JSC_SEL_CAPTURE   4'h8
`define JSC_SEL_RESET     4'h0
`define JSC_CHAIN0        4'h0
`define JSC_CHAIN1        4'h1
`define JSC_CHAIN2        4'h2

// ----------------------------------------------------------------------
// chain lengths and fields
// ----------------------------------------------------------------------
`define JSC_ID_LEN        32
`define JSC_C0_LEN        97
`define JSC_C1_LEN        33
`define JSC_C2_LEN        38
`define JSC_C1_HALT_BIT   32
`define JSC_C2_RW_BIT     37
`define JSC_C2_ADDR_LSB   32
`define JSC_C2_ADDR_LEN   5
`define JSC_DATA_LEN      32

`endif

/* File: rtl/jsc_pkg.sv */
// types for the scan chain and clock switch block
package jsc_pkg;

  // ----------------------------------------------------------------------
  // tap controller states
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    JSC_TLR, JSC_RTI,
    JSC_SEL_DR, JSC_CAP_DR, JSC_SHF_DR, JSC_EX1_DR, JSC_PAU_DR, JSC_EX2_DR, JSC_UPD_DR,
    JSC_SEL_IR, JSC_CAP_IR, JSC_SHF_IR, JSC_EX1_IR, JSC_PAU_IR, JSC_EX2_IR, JSC_UPD_IR
  } jsc_tap_state_e;

  typedef logic [3:0] jsc_instr_t;

endpackage

/* File: rtl/jsc_tap_chains.sv */
// test data registers, scan chains and core clock switch
`timescale 1ns/100ps
`default_nettype none
`include "jsc_map.svh"

module jsc_tap_chains #(
  parameter int          C0_DBUS = 32,
  parameter int          C0_IN   = 33,
  parameter int          C0_OUT  = 32,
  parameter logic [31:0] ID_CODE = 32'h1000_0001  // arbitrary value
) (
  input  wire  logic                sys_clk_i,
  input  wire  logic                reset_n_i,
  input  wire  logic                tck_i,
  input  wire  logic                tms_i,
  input  wire  logic                tdi_i,
  output logic                      tdo_o,
  output logic                      tdo_en_o,
  input  wire  logic                mem_clk_i,
  input  wire  logic                memory_stall_input_i,
  input  wire  logic                debug_req_i,
  input  wire  logic                watchpoint_entry_i,
  output logic                      core_stall_o,
  output logic                      debug_core_clock_o,
  output logic                      selected_clock_output_o,
  output logic                      debug_state_acknowledge_o,
  input  wire  logic [C0_IN-1:0]    c0_sys_in_i,
  output logic       [C0_IN-1:0]    c0_core_in_o,
  input  wire  logic [C0_OUT-1:0]   c0_core_out_i,
  output logic       [C0_OUT-1:0]   c0_sys_out_o,
  input  wire  logic [C0_DBUS-1:0]  c0_dbus_core_i,
  output logic       [C0_DBUS-1:0]  c0_dbus_sys_o,
  input  wire  logic [31:0]         dbus_sys_i,
  input  wire  logic [31:0]         dbus_core_wr_i,
  output logic       [31:0]         dbus_core_o,
  input  wire  logic                halt_request_input_i,
  output logic                      halt_request_core_o,
  output logic                      system_speed_req_o,
  output logic       [4:0]          dreg_addr_o,
  output logic       [31:0]         dreg_wdata_o,
  output logic                      dreg_wr_o,
  output logic                      dreg_rd_o
);

  localparam int C0L = `JSC_C0_LEN;
  localparam int C1L = `JSC_C1_LEN;
  localparam int C2L = `JSC_C2_LEN;
  localparam int CAPW = C0_IN + C0_OUT + C0_DBUS + 32 + 32 + 2;

  if (C0_DBUS + C0_IN + C0_OUT != C0L) begin : g_len_check
    $error("chain 0 cell counts must sum to the chain length");
  end
  if (C0_DBUS < 1 || C0_IN < 1 || C0_OUT < 1) begin : g_min_check
    $error("chain 0 needs every kind of cell");
  end

  // ----------------------------------------------------------------------
  // tck domain reset and input synchronisers
  // ----------------------------------------------------------------------
  logic            rst_s1_r;
  logic            rst_s2_r;
  logic [CAPW-1:0] cap_s1_r;
  logic [CAPW-1:0] cap_s2_r;
  wire  [CAPW-1:0] cap_raw = {watchpoint_entry_i, halt_request_input_i, dbus_core_wr_i,
                              dbus_sys_i, c0_dbus_core_i, c0_core_out_i, c0_sys_in_i};
  wire             trst_n = rst_s2_r;

  always_ff @(posedge tck_i) begin
    rst_s1_r <= reset_n_i;
    rst_s2_r <= rst_s1_r;
    cap_s1_r <= cap_raw;
    cap_s2_r <= cap_s1_r;
  end

  wire [C0_IN-1:0]   s_c0_sys_in  = cap_s2_r[C0_IN-1:0];
  wire [C0_OUT-1:0]  s_c0_core_out = cap_s2_r[C0_IN +: C0_OUT];
  wire [C0_DBUS-1:0] s_c0_dbus    = cap_s2_r[C0_IN+C0_OUT +: C0_DBUS];
  wire [31:0]        s_dbus_sys   = cap_s2_r[C0_IN+C0_OUT+C0_DBUS +: 32];
  wire [31:0]        s_dbus_core  = cap_s2_r[C0_IN+C0_OUT+C0_DBUS+32 +: 32];
  wire               s_halt_in    = cap_s2_r[CAPW-2];
  wire               s_watch      = cap_s2_r[CAPW-1];

  // ----------------------------------------------------------------------
  // tap state machine
  // ----------------------------------------------------------------------
  jsc_pkg::jsc_tap_state_e st_r;
  jsc_pkg::jsc_tap_state_e st_nxt;

  always_comb begin
    unique case (st_r)
      jsc_pkg::JSC_TLR:    st_nxt = tms_i ? jsc_pkg::JSC_TLR    : jsc_pkg::JSC_RTI;
      jsc_pkg::JSC_RTI:    st_nxt = tms_i ? jsc_pkg::JSC_SEL_DR : jsc_pkg::JSC_RTI;
      jsc_pkg::JSC_SEL_DR: st_nxt = tms_i ? jsc_pkg::JSC_SEL_IR : jsc_pkg::JSC_CAP_DR;
      jsc_pkg::JSC_CAP_DR: st_nxt = tms_i ? jsc_pkg::JSC_EX1_DR : jsc_pkg::JSC_SHF_DR;
      jsc_pkg::JSC_SHF_DR: st_nxt = tms_i ? jsc_pkg::JSC_EX1_DR : jsc_pkg::JSC_SHF_DR;
      jsc_pkg::JSC_EX1_DR: st_nxt = tms_i ? jsc_pkg::JSC_UPD_DR : jsc_pkg::JSC_PAU_DR;
      jsc_pkg::JSC_PAU_DR: st_nxt = tms_i ? jsc_pkg::JSC_EX2_DR : jsc_pkg::JSC_PAU_DR;
      jsc_pkg::JSC_EX2_DR: st_nxt = tms_i ? jsc_pkg::JSC_UPD_DR : jsc_pkg::JSC_SHF_DR;
      jsc_pkg::JSC_UPD_DR: st_nxt = tms_i ? jsc_pkg::JSC_SEL_DR : jsc_pkg::JSC_RTI;
      jsc_pkg::JSC_SEL_IR: st_nxt = tms_i ? jsc_pkg::JSC_TLR    : jsc_pkg::JSC_CAP_IR;
      jsc_pkg::JSC_CAP_IR: st_nxt = tms_i ? jsc_pkg::JSC_EX1_IR : jsc_pkg::JSC_SHF_IR;
      jsc_pkg::JSC_SHF_IR: st_nxt = tms_i ? jsc_pkg::JSC_EX1_IR : jsc_pkg::JSC_SHF_IR;
      jsc_pkg::JSC_EX1_IR: st_nxt = tms_i ? jsc_pkg::JSC_UPD_IR : jsc_pkg::JSC_PAU_IR;
      jsc_pkg::JSC_PAU_IR: st_nxt = tms_i ? jsc_pkg::JSC_EX2_IR : jsc_pkg::JSC_PAU_IR;
      jsc_pkg::JSC_EX2_IR: st_nxt = tms_i ? jsc_pkg::JSC_UPD_IR : jsc_pkg::JSC_SHF_IR;
      jsc_pkg::JSC_UPD_IR: st_nxt = tms_i ? jsc_pkg::JSC_SEL_DR : jsc_pkg::JSC_RTI;
    endcase
  end

  always_ff @(posedge tck_i) begin
    if (!trst_n) begin
      st_r <= jsc_pkg::JSC_TLR;
    end else begin
      st_r <= st_nxt;
    end
  end

  wire in_tlr  = (st_r == jsc_pkg::JSC_TLR);
  wire in_rti  = (st_r == jsc_pkg::JSC_RTI);
  wire cap_dr  = (st_r == jsc_pkg::JSC_CAP_DR);
  wire shf_dr  = (st_r == jsc_pkg::JSC_SHF_DR);
  wire upd_dr  = (st_r == jsc_pkg::JSC_UPD_DR);
  wire cap_ir  = (st_r == jsc_pkg::JSC_CAP_IR);
  wire shf_ir  = (st_r == jsc_pkg::JSC_SHF_IR);
  wire upd_ir  = (st_r == jsc_pkg::JSC_UPD_IR);

  // ----------------------------------------------------------------------
  // instruction register and decode
  // ----------------------------------------------------------------------
  jsc_pkg::jsc_instr_t ir_sh_r;
  jsc_pkg::jsc_instr_t ir_cur_r;

  always_ff @(posedge tck_i) begin
    if (!trst_n || in_tlr) begin
      ir_sh_r  <= `JSC_IR_CAPTURE;
      ir_cur_r <= `JSC_IR_BYPASS;
    end else begin
      if (cap_ir) ir_sh_r <= `JSC_IR_CAPTURE;
      else if (shf_ir) ir_sh_r <= {tdi_i, ir_sh_r[3:1]};
      if (upd_ir) ir_cur_r <= ir_sh_r;
    end
  end

  wire is_extest = (ir_cur_r == `JSC_IR_EXTEST);
  wire is_intest = (ir_cur_r == `JSC_IR_INTEST);
  wire is_idcode = (ir_cur_r == `JSC_IR_IDCODE);
  wire is_scan_n = (ir_cur_r == `JSC_IR_SCAN_N);
  wire is_clamp  = (ir_cur_r == `JSC_IR_CLAMP) || (ir_cur_r == `JSC_IR_CLAMPZ);
  // every other code, including the reserved ones, takes the bypass path
  wire is_bypass = !(is_extest || is_intest || is_idcode || is_scan_n);

  // ----------------------------------------------------------------------
  // bypass, identification and chain select registers
  // ----------------------------------------------------------------------
  logic             byp_r;
  logic [31:0]      id_sh_r;
  logic [3:0]       sel_sh_r;
  logic [3:0]       chain_r;

  always_ff @(posedge tck_i) begin
    if (!trst_n) begin
      byp_r    <= 1'b0;
      id_sh_r  <= 32'h0000_0000;
      sel_sh_r <= `JSC_SEL_CAPTURE;
      chain_r  <= `JSC_SEL_RESET;
    end else begin
      if (is_bypass && cap_dr) byp_r <= 1'b0;
      else if (is_bypass && shf_dr) byp_r <= tdi_i;
      if (is_idcode && cap_dr) id_sh_r <= ID_CODE;
      else if (is_idcode && shf_dr) id_sh_r <= {tdi_i, id_sh_r[31:1]};
      if (is_scan_n && cap_dr) sel_sh_r <= `JSC_SEL_CAPTURE;
      else if (is_scan_n && shf_dr) sel_sh_r <= {tdi_i, sel_sh_r[3:1]};
      if (is_scan_n && upd_dr) chain_r <= sel_sh_r;
    end
  end

  wire sel_c0 = (chain_r == `JSC_CHAIN0);
  wire sel_c1 = (chain_r == `JSC_CHAIN1);
  wire sel_c2 = (chain_r == `JSC_CHAIN2);
  wire test_ins = is_intest || is_extest;
  wire c0_act = test_ins && sel_c0;
  wire c1_act = test_ins && sel_c1;
  wire c2_act = test_ins && sel_c2;

  // levels for the system side leave from flip-flops, so a decode glitch cannot cross;
  // they track the next values because tck may stop right after an update
  wire [3:0] ir_cur_nxt = (!trst_n || in_tlr) ? `JSC_IR_BYPASS : (upd_ir ? ir_sh_r : ir_cur_r);
  wire [3:0] chain_nxt  = !trst_n ? `JSC_SEL_RESET : ((is_scan_n && upd_dr) ? sel_sh_r : chain_r);
  logic      byp_lvl_r;
  logic      tst_lvl_r;

  always_ff @(posedge tck_i) begin
    byp_lvl_r <= (ir_cur_nxt == `JSC_IR_BYPASS);
    tst_lvl_r <= (ir_cur_nxt == `JSC_IR_INTEST) && (chain_nxt == `JSC_CHAIN0);
  end

  // ----------------------------------------------------------------------
  // scan chains 0, 1 and 2
  // ----------------------------------------------------------------------
  logic [C0L-1:0]     c0_r;
  logic [C0_DBUS-1:0] c0_upd_r;
  logic [C1L-1:0]     c1_r;
  logic [C2L-1:0]     c2_r;
  logic               first_cap_r;
  logic               ack_t1_r;
  logic               ack_t2_r;
  logic               ack_t3_r;
  logic               wr_r;
  logic               rd_r;

  // lsb of each chain faces tdo, tdi enters at the top
  wire [C0L-1:0] c0_cap = {s_c0_core_out, s_c0_sys_in, s_c0_dbus};
  wire           halt_cap = first_cap_r ? s_watch : s_halt_in;
  wire [C1L-1:0] c1_cap = {halt_cap, is_intest ? s_dbus_core : s_dbus_sys};

  always_ff @(posedge tck_i) begin
    if (!trst_n) begin
      c0_r     <= '0;
      c0_upd_r <= '0;
      c1_r     <= '0;
      c2_r     <= '0;
      ack_t1_r <= 1'b0;
      ack_t2_r <= 1'b0;
      ack_t3_r <= 1'b0;
      first_cap_r <= 1'b0;
      wr_r     <= 1'b0;
      rd_r     <= 1'b0;
    end else begin
      ack_t1_r <= debug_state_acknowledge_o;
      ack_t2_r <= ack_t1_r;
      ack_t3_r <= ack_t2_r;
      if (c0_act && cap_dr) c0_r <= c0_cap;
      else if (c0_act && shf_dr) c0_r <= {tdi_i, c0_r[C0L-1:1]};
      if (c0_act && is_extest && upd_dr) c0_upd_r <= c0_r[C0_DBUS-1:0];
      if (c1_act && cap_dr) c1_r <= c1_cap;
      else if (c1_act && shf_dr) c1_r <= {tdi_i, c1_r[C1L-1:1]};
      // the entry cause is shown once, on the first chain 1 capture after entry
      if (ack_t2_r && !ack_t3_r) first_cap_r <= 1'b1;
      else if (c1_act && cap_dr) first_cap_r <= 1'b0;
      if (c2_act && shf_dr) c2_r <= {tdi_i, c2_r[C2L-1:1]};
      wr_r <= c2_act && upd_dr && c2_r[`JSC_C2_RW_BIT];
      rd_r <= c2_act && upd_dr && !c2_r[`JSC_C2_RW_BIT];
    end
  end

  // only the chain 0 data bus cells have an update stage; other cells drive the serial bits as they move
  wire c0_drv_core = c0_act && is_intest;
  wire c0_drv_sys  = (c0_act && is_extest) || (is_clamp && sel_c0);
  assign c0_core_in_o  = c0_drv_core ? c0_r[C0_DBUS +: C0_IN] : c0_sys_in_i;
  assign c0_sys_out_o  = c0_drv_sys ? c0_r[C0_DBUS+C0_IN +: C0_OUT] : c0_core_out_i;
  assign c0_dbus_sys_o = c0_drv_sys ? c0_upd_r : c0_dbus_core_i;
  assign dbus_core_o   = (c1_act && is_intest) ? c1_r[31:0] : dbus_sys_i;
  assign halt_request_core_o = (c1_act && is_intest) ?
                               c1_r[`JSC_C1_HALT_BIT] : halt_request_input_i;
  assign system_speed_req_o  = c1_r[`JSC_C1_HALT_BIT];
  assign dreg_addr_o  = c2_r[`JSC_C2_ADDR_LSB +: `JSC_C2_ADDR_LEN];
  assign dreg_wdata_o = c2_r[31:0];
  assign dreg_wr_o    = wr_r;
  assign dreg_rd_o    = rd_r;

  // ----------------------------------------------------------------------
  // tdo path, changed on the falling edge
  // ----------------------------------------------------------------------
  wire tdo_dr = is_idcode ? id_sh_r[0] :
                is_scan_n ? sel_sh_r[0] :
                is_bypass ? byp_r :
                sel_c0 ? c0_r[0] :
                sel_c1 ? c1_r[0] :
                sel_c2 ? c2_r[0] : byp_r;
  wire tdo_nxt = shf_ir ? ir_sh_r[0] : tdo_dr;

  always_ff @(negedge tck_i) begin
    if (!trst_n) begin
      tdo_o    <= 1'b0;
      tdo_en_o <= 1'b0;
      debug_core_clock_o <= 1'b0;
    end else begin
      tdo_o    <= tdo_nxt;
      tdo_en_o <= shf_ir || shf_dr;
      // one pulse per idle state; the host is expected to leave after one cycle
      debug_core_clock_o <= in_rti && is_intest && (sel_c0 || sel_c1);
    end
  end

  // ----------------------------------------------------------------------
  // system clock domain: clock switch
  // ----------------------------------------------------------------------
  logic mclk_s1_r;
  logic mclk_s2_r;
  logic mclk_d_r;
  logic debug_core_clock_s1_r;
  logic debug_core_clock_s2_r;
  logic req_s1_r;
  logic req_s2_r;
  logic stall_s1_r;
  logic stall_s2_r;
  logic byp_s1_r;
  logic byp_s2_r;
  logic tst_s1_r;
  logic tst_s2_r;
  logic sel_dbg_r;
  logic armed_r;
  logic ack_nxt;
  logic sel_nxt;

  always_ff @(posedge sys_clk_i) begin
    mclk_s1_r  <= mem_clk_i;
    mclk_s2_r  <= mclk_s1_r;
    debug_core_clock_s1_r  <= debug_core_clock_o;
    debug_core_clock_s2_r  <= debug_core_clock_s1_r;
    req_s1_r   <= debug_req_i;
    req_s2_r   <= req_s1_r;
    stall_s1_r <= memory_stall_input_i;
    stall_s2_r <= stall_s1_r;
    byp_s1_r   <= byp_lvl_r;
    byp_s2_r   <= byp_s1_r;
    tst_s1_r   <= tst_lvl_r;
    tst_s2_r   <= tst_s1_r;
  end

  wire mclk_fall = mclk_d_r && !mclk_s2_r;
  wire leaving   = armed_r && byp_s2_r;
  wire want_dbg  = (debug_state_acknowledge_o && !leaving) || tst_s2_r;
  // switching while both clocks are low cannot clip a pulse
  wire safe_sw   = mclk_fall || (!mclk_s2_r && !debug_core_clock_s2_r);

  assign sel_nxt = safe_sw ? want_dbg : sel_dbg_r;
  assign ack_nxt = (!debug_state_acknowledge_o && req_s2_r && mclk_s2_r) ? 1'b1 :
                   (leaving && !sel_dbg_r) ? 1'b0 : debug_state_acknowledge_o;

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      mclk_d_r  <= 1'b0;
      sel_dbg_r <= 1'b0;
      armed_r   <= 1'b0;
      debug_state_acknowledge_o <= 1'b0;
      selected_clock_output_o   <= 1'b0;
      core_stall_o <= 1'b0;
    end else begin
      mclk_d_r  <= mclk_s2_r;
      sel_dbg_r <= sel_nxt;
      debug_state_acknowledge_o <= ack_nxt;
      if (!ack_nxt) armed_r <= 1'b0;
      else if (!byp_s2_r) armed_r <= 1'b1;
      selected_clock_output_o <= sel_dbg_r ? debug_core_clock_s2_r : mclk_s2_r;
      core_stall_o <= !sel_dbg_r && stall_s2_r;
    end
  end

endmodule
`default_nettype wire

/* File: testbench/jsc_tap_chains_checker.sv */
// concurrent checks on the scan chain block ports
`timescale 1ns/100ps
`default_nettype none
module jsc_tap_chains_checker (
  input wire logic        sys_clk_i,
  input wire logic        reset_n_i,
  input wire logic        tck_i,
  input wire logic        debug_req_i,
  input wire logic        mem_clk_i,
  input wire logic        tdo_en_o,
  input wire logic        debug_core_clock_o,
  input wire logic        debug_state_acknowledge_o,
  input wire logic        selected_clock_output_o,
  input wire logic        core_stall_o,
  input wire logic        dreg_wr_o,
  input wire logic        dreg_rd_o,
  input wire logic        halt_request_input_i,
  input wire logic        halt_request_core_o,
  input wire logic [31:0] dbus_sys_i,
  input wire logic [31:0] dbus_core_o
);
  // --------------------------------------------------------------------
  // properties
  // --------------------------------------------------------------------
  sequence s_low_next(sig);
    ##1 !sig;
  endsequence
  // a pulse that lingers would clock the core or the debug unit twice
  property p_one_tck(sig);
    @(posedge tck_i) disable iff (!reset_n_i) sig |-> s_low_next(sig);
  endproperty
  a_debug_core_clock_one_tck: assert property (p_one_tck(debug_core_clock_o))
    else $error("debug clock high for more than one tck");
  a_wr_one_tck: assert property (p_one_tck(dreg_wr_o))
    else $error("register write pulse too long");
  a_rd_one_tck: assert property (p_one_tck(dreg_rd_o))
    else $error("register read pulse too long");
  a_rd_wr_excl: assert property (@(posedge tck_i) disable iff (!reset_n_i)
    !(dreg_wr_o && dreg_rd_o)) else $error("read and write together");
  a_ack_after_req: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $rose(debug_state_acknowledge_o) |-> $past(debug_req_i, 3))
    else $error("acknowledge without request");
  a_ack_high_phase: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $rose(debug_state_acknowledge_o) |-> $past(mem_clk_i, 3))
    else $error("acknowledge raised outside memory clock high phase");
  a_sys_reset_quiet: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $rose(reset_n_i) |-> !debug_state_acknowledge_o && !selected_clock_output_o
    && !core_stall_o) else $error("clock switch outputs not cleared by reset");
  a_tck_reset_quiet: assert property (@(posedge tck_i) disable iff (!reset_n_i)
    $rose(reset_n_i) |-> !tdo_en_o && !debug_core_clock_o)
    else $error("test port outputs not cleared by reset");
  a_system_mode: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $rose(reset_n_i) |-> halt_request_core_o == halt_request_input_i
    && dbus_core_o == dbus_sys_i) else $error("cells intercept after reset");
endmodule
bind jsc_tap_chains jsc_tap_chains_checker i_chk (
  .sys_clk_i, .reset_n_i, .tck_i, .debug_req_i, .mem_clk_i, .tdo_en_o, .debug_core_clock_o,
  .debug_state_acknowledge_o, .selected_clock_output_o, .core_stall_o, .dreg_wr_o,
  .dreg_rd_o, .halt_request_input_i, .halt_request_core_o, .dbus_sys_i, .dbus_core_o);
`default_nettype wire

/* File: testbench/jsc_jtag_host.sv */
// serial test host model driving the test port
`timescale 1ns/100ps
`default_nettype none
module jsc_jtag_host (
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  input  wire logic tdo_i
);
  // --------------------------------------------------------------------
  // serial access
  // --------------------------------------------------------------------
  // tck stands low between frames; tdi toggles outside shifts
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    #3 tck_o = 1'b1;
    tdo = tdo_i;
    #3 tck_o = 1'b0;
  endtask
  task automatic move(input logic [7:0] seq, input int n);
    logic d;
    for (int i = 0; i < n; i++) step(seq[i], ~tdi_o, d);
  endtask
  task automatic tap_reset();
    move(8'h1F, 6);
  endtask
  // ends after a single idle cycle: a longer stay would clock the core again
  task automatic scan(input logic ir, input int n, input logic [127:0] din,
                      output logic [127:0] dout);
    logic d;
    dout = '0;
    if (ir) move(8'h03, 4);
    else move(8'h01, 3);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], d);
      dout[i] = d;
    end
    move(8'h01, 2);
  endtask
endmodule
`default_nettype wire

/* File: testbench/jsc_tap_chains_tb.sv */
// self-checking bench for the scan chain and clock switch block
`timescale 1ns/100ps
`default_nettype none
`include "jsc_map.svh"
module jsc_tap_chains_tb;
  localparam logic [31:0]  ID   = 32'h5A5A_0003;  // arbitrary value
  localparam logic [37:0]  C2W  = {1'b1, 5'h15, 32'hC3A5_0F96};
  localparam logic [33:0]  P1   = 34'h2_8765_4321;
  localparam logic [97:0]  P0   = 98'h2_9E37_79B9_7F4A_7C15_F39C_C061;
  localparam logic [3:0]   ODD [8] = '{4'h1, 4'h4, 4'h6, 4'h8, 4'hA, 4'hB, 4'hD, 4'hF};
  logic        sys_clk_i, reset_n_i, tck_i, tms_i, tdi_i, tdo_o, tdo_en_o, mem_clk_i = 1'b0;
  logic        memory_stall_input_i, debug_req_i, watchpoint_entry_i, core_stall_o;
  logic        debug_core_clock_o, selected_clock_output_o, debug_state_acknowledge_o;
  logic        halt_request_input_i, halt_request_core_o, system_speed_req_o;
  logic        dreg_wr_o, dreg_rd_o, mem_run, b;
  logic [32:0] c0_sys_in_i, c0_core_in_o;
  logic [31:0] c0_core_out_i, c0_sys_out_o, c0_dbus_core_i, c0_dbus_sys_o;
  logic [31:0] dbus_sys_i, dbus_core_wr_i, dbus_core_o, dreg_wdata_o, wd;
  logic [4:0]  dreg_addr_o, wa;
  logic [2:0]  mdiv = 3'h0;
  logic [127:0] q;
  int          failures, n_checks, cyc, n_debug_core_clock, n_wr, n_rd, nd, n_en;

  jsc_tap_chains #(.ID_CODE(ID)) i_dut (.*);
  jsc_jtag_host i_host (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i), .tdo_i(tdo_o));

  // --------------------------------------------------------------------
  // clocks, monitors and helpers
  // --------------------------------------------------------------------
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge tck_i) begin
    if (debug_core_clock_o) n_debug_core_clock++;
    if (tdo_en_o) n_en++;
    if (dreg_rd_o) n_rd++;
    if (dreg_wr_o) begin
      n_wr++;
      wa = dreg_addr_o;
      wd = dreg_wdata_o;
    end
  end
  always @(posedge sys_clk_i) begin
    cyc++;
    mdiv <= (mdiv == 3'h4) ? 3'h0 : mdiv + 3'h1;
    if (mdiv == 3'h4 && mem_run) mem_clk_i <= ~mem_clk_i;
    if (cyc == 8000) begin
      failures++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ir(input logic [3:0] c);
    i_host.scan(1'b1, 4, {124'h0, c}, q);
  endtask
  task automatic dr(input int n, input logic [127:0] d);
    i_host.scan(1'b0, n, d, q);
  endtask
  task automatic wait_ack(input logic v);
    for (int i = 0; i < 300 && debug_state_acknowledge_o !== v; i++) @(posedge sys_clk_i);
  endtask
  // the chosen clock trails the memory clock by the three-flop sync path
  task automatic selected_clock_output_check(input logic v);
    @(posedge mem_clk_i);
    repeat (4) @(posedge sys_clk_i);
    check(selected_clock_output_o, v);
  endtask

  // --------------------------------------------------------------------
  // test sequence
  // --------------------------------------------------------------------
  initial begin
    reset_n_i = 1'b0;
    mem_run = 1'b0;
    memory_stall_input_i = 1'b0;
    debug_req_i = 1'b0;
    watchpoint_entry_i = 1'b1;
    halt_request_input_i = 1'b0;
    c0_sys_in_i = 33'h1_2345_6789;
    c0_core_out_i = 32'h0F0F_3C3C;
    c0_dbus_core_i = 32'hA5A5_5A5A;
    dbus_sys_i = 32'h2468_ACE0;
    dbus_core_wr_i = 32'h1357_9BDF;
    repeat (4) i_host.step(1'b1, 1'b0, b);
    @(posedge sys_clk_i) reset_n_i <= 1'b1;
    i_host.tap_reset();
    dr(8, 128'hB5);
    check(q, 128'h6A);
    check(n_en, 8);
    ir(`JSC_IR_IDCODE);
    check(q, `JSC_IR_CAPTURE);
    dr(32, 128'h0);
    check(q, {96'h0, ID});
    foreach (ODD[i]) begin
      ir(ODD[i]);
      dr(8, 128'hB5);
      check(q, 128'h6A);
    end
    ir(`JSC_IR_SCAN_N);
    dr(4, `JSC_CHAIN2);
    check(q, `JSC_SEL_CAPTURE);
    ir(`JSC_IR_INTEST);
    dr(38, C2W);
    dr(38, {1'b0, 5'h0A, 32'h0});
    check(q, C2W);
    ir(`JSC_IR_SCAN_N);
    check({wa, wd}, C2W[36:0]);
    check(n_wr * 2 + n_rd, 3);
    dr(4, `JSC_CHAIN1);
    ir(`JSC_IR_INTEST);
    dr(34, P1);
    check(q, {94'h0, 1'b1, 1'b0, dbus_core_wr_i});
    check({system_speed_req_o, halt_request_core_o, dbus_core_o}, {P1[33], P1[33:1]});
    ir(`JSC_IR_SCAN_N);
    dr(4, `JSC_CHAIN0);
    nd = n_debug_core_clock;
    ir(`JSC_IR_EXTEST);
    dr(98, P0);
    check({q[97], q[64:32]}, {P0[0], c0_sys_in_i});
    check({c0_sys_out_o, c0_dbus_sys_o}, {P0[97:66], P0[32:1]});
    ir(`JSC_IR_INTEST);
    check(n_debug_core_clock - nd, 0);
    dr(97, P0);
    nd = n_debug_core_clock;
    dr(97, P0);
    check({n_debug_core_clock - nd, q[96:65]}, {32'h1, c0_core_out_i});
    check(c0_core_in_o, P0[64:32]);
    ir(`JSC_IR_BYPASS);
    @(posedge sys_clk_i) begin
      mem_run <= 1'b1;
      memory_stall_input_i <= 1'b1;
    end
    repeat (20) @(posedge sys_clk_i);
    check(core_stall_o, 1'b1);
    selected_clock_output_check(1'b1);
    @(posedge sys_clk_i) debug_req_i <= 1'b1;
    wait_ack(1'b1);
    check(debug_state_acknowledge_o, 1'b1);
    repeat (60) @(posedge sys_clk_i);
    check(core_stall_o, 1'b0);
    selected_clock_output_check(1'b0);
    ir(`JSC_IR_SCAN_N);
    dr(4, `JSC_CHAIN1);
    ir(`JSC_IR_INTEST);
    dr(33, 128'h0);
    check(q[32], 1'b1);
    @(posedge sys_clk_i) debug_req_i <= 1'b0;
    ir(`JSC_IR_BYPASS);
    wait_ack(1'b0);
    check(debug_state_acknowledge_o, 1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire
